// ---- design/ect_defines.svh ----
// Register offsets, value limits, reset values and timing counts of the event counter and pulse timer
`ifndef ECT_DEFINES_SVH
`define ECT_DEFINES_SVH
`define ADDR_COUNT_UNIT_SEL    8'h00
`define ADDR_INC_SOURCE_SEL    8'h04
`define ADDR_INC_EDGE_SEL      8'h08
`define ADDR_CLR_SOURCE_SEL    8'h0C
`define ADDR_CLR_EDGE_SEL      8'h10
`define ADDR_COUNT_LIMIT       8'h14
`define ADDR_COUNT_NOW         8'h18
`define ADDR_COUNT_SNAPSHOT    8'h1C
`define ADDR_COUNT_RESTART     8'h20
`define ADDR_COUNT_STATUS      8'h24
`define ADDR_FRAME_SEQ         8'h28
`define ADDR_META_ENABLE       8'h2C
`define ADDR_PULSE_UNIT_SEL    8'h30
`define ADDR_PULSE_DELAY_US    8'h34
`define ADDR_PULSE_WIDTH_US    8'h38
`define ADDR_PULSE_SRC_SEL     8'h3C
`define ADDR_PULSE_EDGE_SEL    8'h40
`define ADDR_PULSE_STATUS      8'h44
`define CLOCK_MHZ              50
`define US_CYCLES              (`CLOCK_MHZ)
`define PULSE_WIDTH_MIN_US     21'd10
`define PULSE_WIDTH_MAX_US     21'd2000000
`define PULSE_DELAY_MAX_US     21'd2000000
`define COUNT_LIMIT_RESET      16'hFFFF
`define PULSE_WIDTH_RESET      21'd10
`endif

// ---- design/ect_pkg.sv ----
// Types shared by the event counter and pulse timer
package ect_pkg;
  typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_ANY} edge_sel_t;
  typedef enum logic [3:0] {
    SRC_UNIT_ONE_DONE, SRC_UNIT_TWO_DONE, SRC_SHUTTER_LEVEL, SRC_FRAME_DROP,
    SRC_IO_PIN_0, SRC_IO_PIN_1, SRC_IO_PIN_2, SRC_FRAME_START, SRC_TRIGGER_DROP, SRC_OFF
  } count_src_t;
  typedef enum logic [2:0] {
    PSRC_SHUTTER_CLOSE, PSRC_SHUTTER_OPEN, PSRC_FRAME_DROP, PSRC_TRIGGER_DROP,
    PSRC_IO_PIN_0, PSRC_IO_PIN_1, PSRC_OFF
  } pulse_src_t;
  typedef enum logic [1:0] {P_IDLE, P_DELAY, P_PULSE} pulse_state_t;
endpackage

// ---- design/edge_detect.sv ----
// Selectable edge detector on a same-domain level
`timescale 1ns/10ps
`default_nettype none
module edge_detect (
  input  wire logic            clock,
  input  wire logic            nrst,
  input  wire logic            level,
  input  wire logic            enable,
  input  wire ect_pkg::edge_sel_t sel,
  output logic                 hit
);
  logic prev_q;

  always_ff @(posedge clock)
  begin
    if (!nrst)
      prev_q <= 1'b0;
    else
      prev_q <= level;
  end

  always_comb
  begin
    unique case (sel)
      ect_pkg::EDGE_RISE: hit = enable & level & ~prev_q;
      ect_pkg::EDGE_FALL: hit = enable & ~level & prev_q;
      ect_pkg::EDGE_ANY:  hit = enable & (level ^ prev_q);
      default:            hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ---- design/count_unit.sv ----
// One event counter with limit, clear and snapshot
`timescale 1ns/10ps
`default_nettype none
`include "ect_defines.svh"
module count_unit (
  input  wire logic                clock,
  input  wire logic                nrst,
  input  wire logic [9:0]          sources,
  input  wire ect_pkg::count_src_t inc_source_sel,
  input  wire ect_pkg::edge_sel_t  inc_edge_sel,
  input  wire ect_pkg::count_src_t clr_source_sel,
  input  wire ect_pkg::edge_sel_t  clr_edge_sel,
  input  wire logic [15:0]         count_limit,
  input  wire logic                count_restart_cmd,
  input  wire logic                preload,
  input  wire logic [15:0]         preload_value,
  output logic [15:0]              count_now,
  output logic [15:0]              count_snapshot,
  output logic                     limit_reached_flag,
  output logic                     count_done_event
);
  logic inc_hit;
  logic clr_hit;
  logic inc_level;
  logic clr_level;
  logic clear;
  logic clr_on;
  ect_pkg::count_src_t inc_sel_q;
  ect_pkg::count_src_t clr_sel_q;

  // Switching the source is not an edge of it: mask the cycle after a change
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      inc_sel_q <= ect_pkg::SRC_OFF;
      clr_sel_q <= ect_pkg::SRC_OFF;
    end
    else
    begin
      inc_sel_q <= inc_source_sel;
      clr_sel_q <= clr_source_sel;
    end
  end

  assign clr_on = clr_source_sel != ect_pkg::SRC_OFF && clr_source_sel != ect_pkg::SRC_TRIGGER_DROP
                  && clr_source_sel == clr_sel_q;

  assign inc_level = sources[inc_source_sel];
  assign clr_level = sources[clr_source_sel];

  edge_detect inc_det (
    .clock  (clock),
    .nrst   (nrst),
    .level  (inc_level),
    .enable (inc_source_sel != ect_pkg::SRC_OFF && inc_source_sel == inc_sel_q),
    .sel    (inc_edge_sel),
    .hit    (inc_hit)
  );

  edge_detect clr_det (
    .clock  (clock),
    .nrst   (nrst),
    .level  (clr_level),
    .enable (clr_on),
    .sel    (clr_edge_sel),
    .hit    (clr_hit)
  );

  assign clear = clr_hit | count_restart_cmd;

  always_ff @(posedge clock)
  begin
    if (!nrst)
      count_now <= 16'h0000;
    else if (clear)
      count_now <= 16'h0000;
    else if (preload)
      count_now <= preload_value;
    else if (inc_hit && !limit_reached_flag && count_now != count_limit)
      count_now <= count_now + 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      count_snapshot <= 16'h0000;
    else if (clear)
      count_snapshot <= count_now;
  end

  // Done fires once when the count lands on the limit; the limit flag is held until a clear
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      limit_reached_flag <= 1'b0;
      count_done_event   <= 1'b0;
    end
    else if (clear)
    begin
      limit_reached_flag <= 1'b0;
      count_done_event   <= 1'b0;
    end
    else
    begin
      count_done_event   <= !limit_reached_flag && count_now == count_limit;
      if (count_now == count_limit)
        limit_reached_flag <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- design/event_counter_pulse_timer.sv ----
// Top: two event counters, a delayed pulse timer, frame sequence counter and register port
// Summary of operation
// - At the limit, emit done event, set limit flag, hold count until clear.
// - Count limit is software-written, 0 to 65535.
// - Increment on rising, falling or either edge of the source.
// - Increment source: unit done, shutter level, drops, pins, frame start, off.
// - Increment source off suspends counting without clearing.
// - Restart command clears and restarts the selected counter.
// - Restart clears regardless of clear source or edge setting.
// - Every clear latches the prior count into a read-only snapshot.
// - Clear on rising, falling or either edge of the clear source.
// - Clear source: unit done, shutter level, frame drop, pins, frame start, off.
// - Two counters; a unit select steers configuration and value access.
// - Current count readable and writable; a write preloads it.
// - 32-bit frame sequence counter inserted into metadata when enabled.
// - Software write loads the frame sequence counter.
// - Timer waits a programmed delay in microseconds after the trigger edge.
// - Timer pulse width 10 to 2000000 microseconds.
// - Timer starts on rising, falling or either trigger edge.
// - Timer trigger: shutter close, shutter open, drops, pins 0 and 1, off.
// - Timer unit select is stored and read back only; one timer, so it steers no accesses.
`timescale 1ns/10ps
`default_nettype none
`include "ect_defines.svh"
module event_counter_pulse_timer (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  input  wire logic        shutter_open_level,
  input  wire logic        frame_drop_flag,
  input  wire logic        trigger_drop_flag,
  input  wire logic        frame_start_pulse,
  input  wire logic        io_pin_0,
  input  wire logic        io_pin_1,
  input  wire logic        io_pin_2,
  output logic             unit_one_done,
  output logic             unit_two_done,
  output logic             limit_one_flag,
  output logic             limit_two_flag,
  output logic             timer_pulse,
  output logic [31:0]      meta_frame_seq,
  output logic             meta_frame_valid
);
  // Pins cross from outside: two flip-flops each
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end
    else
    begin
      pin_meta_q <= {io_pin_2, io_pin_1, io_pin_0};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Configuration registers
  logic                count_unit_sel_q;
  ect_pkg::count_src_t inc_src_q [2];
  ect_pkg::edge_sel_t  inc_edge_q [2];
  ect_pkg::count_src_t clr_src_q [2];
  ect_pkg::edge_sel_t  clr_edge_q [2];
  logic [15:0]         limit_q [2];
  logic                meta_enable_q;
  logic [31:0]         frame_seq_number;
  ect_pkg::pulse_src_t pulse_src_q;
  ect_pkg::edge_sel_t  pulse_edge_q;
  logic [20:0]         pulse_delay_us_q;
  logic [20:0]         pulse_width_us_q;
  logic                pulse_unit_sel_q;

  logic [15:0] count_now [2];
  logic [15:0] count_snapshot [2];
  logic [1:0]  limit_flag;
  logic [1:0]  done_ev;
  logic [9:0]  sources;
  logic        wsel;

  assign wsel = count_unit_sel_q;

  // Source vector indexed by count_src_t encoding
  assign sources = {1'b0, trigger_drop_flag, frame_start_pulse, pin_sync_q[2], pin_sync_q[1],
                    pin_sync_q[0], frame_drop_flag, shutter_open_level, done_ev[1], done_ev[0]};

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      count_unit_sel_q <= 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        inc_src_q[i]  <= ect_pkg::SRC_OFF;
        inc_edge_q[i] <= ect_pkg::EDGE_RISE;
        clr_src_q[i]  <= ect_pkg::SRC_OFF;
        clr_edge_q[i] <= ect_pkg::EDGE_RISE;
        limit_q[i]    <= `COUNT_LIMIT_RESET;
      end
    end
    else if (wr)
    begin
      unique case (addr)
        `ADDR_COUNT_UNIT_SEL: count_unit_sel_q <= wdata[0];
        `ADDR_INC_SOURCE_SEL:
          if (wdata[3:0] <= 4'h9)
            inc_src_q[wsel] <= ect_pkg::count_src_t'(wdata[3:0]);
        `ADDR_INC_EDGE_SEL:
          if (wdata[1:0] != 2'h3)
            inc_edge_q[wsel] <= ect_pkg::edge_sel_t'(wdata[1:0]);
        `ADDR_CLR_SOURCE_SEL:
          if (wdata[3:0] <= 4'h9 && wdata[3:0] != 4'h8)
            clr_src_q[wsel] <= ect_pkg::count_src_t'(wdata[3:0]);
        `ADDR_CLR_EDGE_SEL:
          if (wdata[1:0] != 2'h3)
            clr_edge_q[wsel] <= ect_pkg::edge_sel_t'(wdata[1:0]);
        `ADDR_COUNT_LIMIT: limit_q[wsel] <= wdata[15:0];
        default: ;
      endcase
    end
  end

  // Pulse timer configuration; one instance, so the unit select only stores its choice
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pulse_unit_sel_q <= 1'b0;
      pulse_src_q      <= ect_pkg::PSRC_OFF;
      pulse_edge_q     <= ect_pkg::EDGE_RISE;
      pulse_delay_us_q <= 21'd0;
      pulse_width_us_q <= `PULSE_WIDTH_RESET;
      meta_enable_q    <= 1'b0;
    end
    else if (wr)
    begin
      unique case (addr)
        `ADDR_PULSE_UNIT_SEL: pulse_unit_sel_q <= wdata[0];
        `ADDR_PULSE_SRC_SEL:
          if (wdata[2:0] <= 3'h6)
            pulse_src_q <= ect_pkg::pulse_src_t'(wdata[2:0]);
        `ADDR_PULSE_EDGE_SEL:
          if (wdata[1:0] != 2'h3)
            pulse_edge_q <= ect_pkg::edge_sel_t'(wdata[1:0]);
        `ADDR_PULSE_DELAY_US:
          if (wdata[20:0] <= `PULSE_DELAY_MAX_US && wdata[31:21] == 11'h000)
            pulse_delay_us_q <= wdata[20:0];
        `ADDR_PULSE_WIDTH_US:
          if (wdata[20:0] >= `PULSE_WIDTH_MIN_US && wdata[20:0] <= `PULSE_WIDTH_MAX_US
              && wdata[31:21] == 11'h000)
            pulse_width_us_q <= wdata[20:0];
        `ADDR_META_ENABLE: meta_enable_q <= wdata[0];
        default: ;
      endcase
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_unit
    count_unit unit (
      .clock              (clock),
      .nrst               (nrst),
      .sources            (sources),
      .inc_source_sel     (inc_src_q[g]),
      .inc_edge_sel       (inc_edge_q[g]),
      .clr_source_sel     (clr_src_q[g]),
      .clr_edge_sel       (clr_edge_q[g]),
      .count_limit        (limit_q[g]),
      .count_restart_cmd  (wr && addr == `ADDR_COUNT_RESTART && wsel == 1'(g)),
      .preload            (wr && addr == `ADDR_COUNT_NOW && wsel == 1'(g)),
      .preload_value      (wdata[15:0]),
      .count_now          (count_now[g]),
      .count_snapshot     (count_snapshot[g]),
      .limit_reached_flag (limit_flag[g]),
      .count_done_event   (done_ev[g])
    );
  end

  assign unit_one_done  = done_ev[0];
  assign unit_two_done  = done_ev[1];
  assign limit_one_flag = limit_flag[0];
  assign limit_two_flag = limit_flag[1];

  // Frame sequence counter
  always_ff @(posedge clock)
  begin
    if (!nrst)
      frame_seq_number <= 32'h00000000;
    else if (wr && addr == `ADDR_FRAME_SEQ)
      frame_seq_number <= wdata;
    else if (frame_start_pulse)
      frame_seq_number <= frame_seq_number + 32'h00000001;
  end

  // Metadata tag captured per frame while enabled
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      meta_frame_seq   <= 32'h00000000;
      meta_frame_valid <= 1'b0;
    end
    else
    begin
      meta_frame_valid <= frame_start_pulse && meta_enable_q;
      if (frame_start_pulse && meta_enable_q)
        meta_frame_seq <= frame_seq_number;
    end
  end

  // Pulse timer
  ect_pkg::pulse_src_t   pulse_src_prev_q;
  logic                  pulse_level;
  logic                  pulse_hit;
  logic [5:0]            us_div_q;
  logic                  us_tick;
  logic [20:0]           us_cnt_q;
  ect_pkg::pulse_state_t pstate_q;

  always_ff @(posedge clock)
  begin
    if (!nrst)
      pulse_src_prev_q <= ect_pkg::PSRC_OFF;
    else
      pulse_src_prev_q <= pulse_src_q;
  end

  // Open and close are shutter-level edges, so both map onto the level with a fixed sense
  always_comb
  begin
    unique case (pulse_src_q)
      ect_pkg::PSRC_SHUTTER_CLOSE: pulse_level = ~shutter_open_level;
      ect_pkg::PSRC_SHUTTER_OPEN:  pulse_level = shutter_open_level;
      ect_pkg::PSRC_FRAME_DROP:    pulse_level = frame_drop_flag;
      ect_pkg::PSRC_TRIGGER_DROP:  pulse_level = trigger_drop_flag;
      ect_pkg::PSRC_IO_PIN_0:      pulse_level = pin_sync_q[0];
      ect_pkg::PSRC_IO_PIN_1:      pulse_level = pin_sync_q[1];
      default:                     pulse_level = 1'b0;
    endcase
  end

  edge_detect pulse_det (
    .clock  (clock),
    .nrst   (nrst),
    .level  (pulse_level),
    // A source switch is not a trigger edge, so the cycle after it is masked
    .enable (pulse_src_q != ect_pkg::PSRC_OFF && pulse_src_q == pulse_src_prev_q),
    .sel    (pulse_edge_q),
    .hit    (pulse_hit)
  );

  // Microsecond tick, restarted at each accepted trigger so delays are exact
  assign us_tick = us_div_q == 6'(`US_CYCLES - 1);

  always_ff @(posedge clock)
  begin
    if (!nrst || pstate_q == ect_pkg::P_IDLE || us_tick)
      us_div_q <= 6'h00;
    else
      us_div_q <= us_div_q + 6'h01;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pstate_q    <= ect_pkg::P_IDLE;
      us_cnt_q    <= 21'd0;
      timer_pulse <= 1'b0;
    end
    else
    begin
      unique case (pstate_q)
        ect_pkg::P_IDLE:
          if (pulse_hit)
          begin
            us_cnt_q <= pulse_delay_us_q;
            if (pulse_delay_us_q == 21'd0)
            begin
              pstate_q    <= ect_pkg::P_PULSE;
              us_cnt_q    <= pulse_width_us_q;
              timer_pulse <= 1'b1;
            end
            else
              pstate_q <= ect_pkg::P_DELAY;
          end
        ect_pkg::P_DELAY:
          if (us_tick)
          begin
            if (us_cnt_q == 21'd1)
            begin
              pstate_q    <= ect_pkg::P_PULSE;
              us_cnt_q    <= pulse_width_us_q;
              timer_pulse <= 1'b1;
            end
            else
              us_cnt_q <= us_cnt_q - 21'd1;
          end
        ect_pkg::P_PULSE:
          if (us_tick)
          begin
            if (us_cnt_q == 21'd1)
            begin
              pstate_q    <= ect_pkg::P_IDLE;
              timer_pulse <= 1'b0;
            end
            else
              us_cnt_q <= us_cnt_q - 21'd1;
          end
        default: pstate_q <= ect_pkg::P_IDLE;
      endcase
    end
  end

  // Read port: data in the cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (!nrst)
      rdata <= 32'h00000000;
    else if (rd)
    begin
      unique case (addr)
        `ADDR_COUNT_UNIT_SEL: rdata <= {31'h0, count_unit_sel_q};
        `ADDR_INC_SOURCE_SEL: rdata <= {28'h0, inc_src_q[wsel]};
        `ADDR_INC_EDGE_SEL:   rdata <= {30'h0, inc_edge_q[wsel]};
        `ADDR_CLR_SOURCE_SEL: rdata <= {28'h0, clr_src_q[wsel]};
        `ADDR_CLR_EDGE_SEL:   rdata <= {30'h0, clr_edge_q[wsel]};
        `ADDR_COUNT_LIMIT:    rdata <= {16'h0, limit_q[wsel]};
        `ADDR_COUNT_NOW:      rdata <= {16'h0, count_now[wsel]};
        `ADDR_COUNT_SNAPSHOT: rdata <= {16'h0, count_snapshot[wsel]};
        `ADDR_COUNT_STATUS:   rdata <= {30'h0, limit_flag};
        `ADDR_FRAME_SEQ:      rdata <= frame_seq_number;
        `ADDR_META_ENABLE:    rdata <= {31'h0, meta_enable_q};
        `ADDR_PULSE_UNIT_SEL: rdata <= {31'h0, pulse_unit_sel_q};
        `ADDR_PULSE_DELAY_US: rdata <= {11'h0, pulse_delay_us_q};
        `ADDR_PULSE_WIDTH_US: rdata <= {11'h0, pulse_width_us_q};
        `ADDR_PULSE_SRC_SEL:  rdata <= {29'h0, pulse_src_q};
        `ADDR_PULSE_EDGE_SEL: rdata <= {30'h0, pulse_edge_q};
        `ADDR_PULSE_STATUS:   rdata <= {29'h0, timer_pulse, pstate_q};
        default:              rdata <= 32'h00000000;
      endcase
    end
    else
      rdata <= 32'h00000000;
  end
endmodule
`default_nettype wire

// ---- verif/ect_properties.sv ----
// Port-level concurrent checks for the event counter and pulse timer
`timescale 1ns/10ps
`default_nettype none
module ect_checker (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        frame_start_pulse,
  input wire logic        unit_one_done,
  input wire logic        unit_two_done,
  input wire logic        limit_one_flag,
  input wire logic        limit_two_flag,
  input wire logic        timer_pulse,
  input wire logic [31:0] meta_frame_seq,
  input wire logic        meta_frame_valid
);
  // Shortest legal pulse is 10 us at 50 cycles per us
  localparam int MIN_HIGH = 500;
  int unsigned hi_q;
  always_ff @(posedge clock)
  begin
    if (!nrst || !timer_pulse)
      hi_q <= 0;
    else
      hi_q <= hi_q + 1;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside the read answer cycle");
  a_done_one_pulse: assert property (unit_one_done |=> !unit_one_done)
    else $error("unit one done longer than one cycle");
  a_done_sets_flag: assert property (unit_one_done |-> limit_one_flag)
    else $error("unit one done without limit flag");
  a_flag_rise_done: assert property ($rose(limit_one_flag) |-> unit_one_done)
    else $error("unit one limit flag rose without done event");
  a_done2_flag_pulse: assert property (unit_two_done |-> limit_two_flag ##1 !unit_two_done)
    else $error("unit two done without flag or too long");
  a_meta_after_frame: assert property (meta_frame_valid |-> $past(frame_start_pulse))
    else $error("metadata valid without a frame start");
  a_meta_seq_hold: assert property ($changed(meta_frame_seq) |-> meta_frame_valid)
    else $error("metadata sequence changed outside a frame");
  a_pulse_min_width: assert property ($fell(timer_pulse) |-> hi_q >= MIN_HIGH)
    else $error("timer pulse shorter than the minimum width");
  c_unit_done: cover property (unit_one_done);
  c_unit_two_done: cover property (unit_two_done);
  c_pulse_start: cover property ($rose(timer_pulse));
  c_meta_frame: cover property (meta_frame_valid);
endmodule
bind event_counter_pulse_timer ect_checker u_chk (
  .clock             (clock),
  .nrst              (nrst),
  .rd                (rd),
  .rdata             (rdata),
  .frame_start_pulse (frame_start_pulse),
  .unit_one_done     (unit_one_done),
  .unit_two_done     (unit_two_done),
  .limit_one_flag    (limit_one_flag),
  .limit_two_flag    (limit_two_flag),
  .timer_pulse       (timer_pulse),
  .meta_frame_seq    (meta_frame_seq),
  .meta_frame_valid  (meta_frame_valid)
);
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking bench for the event counter and pulse timer
`timescale 1ns/10ps
`default_nettype none
`include "ect_defines.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fail_count++; \
  $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  // Sources: shutter, frame drop, trigger drop, frame start, pins 0 to 2
  logic [6:0]  src = 7'h00;
  logic [31:0] rdata, rd_val, meta_frame_seq, fseq;
  logic        unit_one_done, unit_two_done, limit_one_flag, limit_two_flag, timer_pulse, meta_frame_valid;
  logic [15:0] seed = 16'h0063;
  int          fail_count = 0;
  int          tests_run = 0;
  int          done_ones = 0;
  int          n, prior;
  always #10 clock = ~clock;
  always @(posedge clock)
    if (unit_one_done === 1'b1)
      done_ones <= done_ones + 1;
  event_counter_pulse_timer dut (
    .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .shutter_open_level(src[0]), .frame_drop_flag(src[1]), .trigger_drop_flag(src[2]),
    .frame_start_pulse(src[3]), .io_pin_0(src[4]), .io_pin_1(src[5]), .io_pin_2(src[6]),
    .unit_one_done(unit_one_done), .unit_two_done(unit_two_done), .limit_one_flag(limit_one_flag),
    .limit_two_flag(limit_two_flag), .timer_pulse(timer_pulse), .meta_frame_seq(meta_frame_seq),
    .meta_frame_valid(meta_frame_valid)
  );
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function int edges_seen(input int e, input int rises, input int falls);
    return (e == 0) ? rises : (e == 1) ? falls : rises + falls;
  endfunction
  task end_of_test;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task rr_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    rd_val = rdata;
    `CHK(nm, ex, rd_val)
  endtask
  task wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] ex, input string nm);
    wreg(a, d);
    rr_chk(a, ex, nm);
  endtask
  task tog(input int i);
    @(posedge clock);
    src[i] <= ~src[i];
    repeat (6) @(posedge clock);
  endtask
  // Bounded wait on the timer output; running out ends the run
  task wait_pulse(input logic lvl, output int cyc);
    cyc = 0;
    while (timer_pulse !== lvl)
    begin
      @(posedge clock);
      #1;
      cyc++;
      if (cyc > 2000)
      begin
        fail_count++;
        end_of_test;
      end
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    rr_chk(`ADDR_COUNT_LIMIT, 32'h0000FFFF, "limit reset");
    rr_chk(`ADDR_PULSE_WIDTH_US, 32'h0000000A, "width reset");
    rr_chk(8'h50, 32'h0, "unmapped read");
    wr_chk(`ADDR_INC_EDGE_SEL, 32'h3, 32'h0, "edge refused");
    wr_chk(`ADDR_CLR_SOURCE_SEL, 32'h8, 32'h9, "clear source refused");
    wr_chk(`ADDR_PULSE_WIDTH_US, 32'h5, 32'hA, "width refused");
    wr_chk(`ADDR_PULSE_DELAY_US, 32'h001E8481, 32'h0, "delay refused");
    $display("test reset and refusals done");
    wreg(`ADDR_INC_SOURCE_SEL, 32'h3);
    prior = 0;
    for (int e = 0; e < 3; e++)
    begin
      wreg(`ADDR_INC_EDGE_SEL, e);
      wreg(`ADDR_COUNT_RESTART, 32'h0);
      rr_chk(`ADDR_COUNT_SNAPSHOT, prior, "snapshot on restart");
      rr_chk(`ADDR_COUNT_NOW, 32'h0, "count after restart");
      repeat (4) tog(1);
      prior = edges_seen(e, 2, 2);
      rr_chk(`ADDR_COUNT_NOW, prior, "count per edge mode");
    end
    wreg(`ADDR_INC_SOURCE_SEL, 32'h9);
    repeat (2) tog(1);
    rr_chk(`ADDR_COUNT_NOW, prior, "count with source off");
    $display("test edge modes done");
    wreg(`ADDR_INC_SOURCE_SEL, 32'h3);
    wreg(`ADDR_INC_EDGE_SEL, 32'h0);
    wreg(`ADDR_COUNT_LIMIT, 32'h3);
    wreg(`ADDR_COUNT_RESTART, 32'h0);
    n = done_ones;
    repeat (10) tog(1);
    rr_chk(`ADDR_COUNT_NOW, 32'h3, "count held at limit");
    `CHK("done events", 1, done_ones - n)
    rr_chk(`ADDR_COUNT_STATUS, 32'h1, "status flags");
    wreg(`ADDR_CLR_SOURCE_SEL, 32'h2);
    wreg(`ADDR_CLR_EDGE_SEL, 32'h0);
    tog(0);
    rr_chk(`ADDR_COUNT_NOW, 32'h0, "count after hardware clear");
    `CHK("flag after clear", 1'b0, limit_one_flag)
    rr_chk(`ADDR_COUNT_SNAPSHOT, 32'h3, "snapshot on hardware clear");
    repeat (2) tog(1);
    tog(0);
    rr_chk(`ADDR_COUNT_NOW, 32'h1, "falling edge ignored");
    wreg(`ADDR_CLR_SOURCE_SEL, 32'h9);
    $display("test limit and clear done");
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      wreg(`ADDR_COUNT_UNIT_SEL, 32'h1);
      wreg(`ADDR_COUNT_NOW, {16'h0, ~seed});
      wreg(`ADDR_COUNT_UNIT_SEL, 32'h0);
      wr_chk(`ADDR_COUNT_NOW, {16'h0, seed}, {16'h0, seed}, "preload unit one");
      wreg(`ADDR_COUNT_UNIT_SEL, 32'h1);
      rr_chk(`ADDR_COUNT_NOW, {16'h0, ~seed}, "preload unit two");
    end
    wreg(`ADDR_INC_SOURCE_SEL, 32'h3);
    wreg(`ADDR_COUNT_LIMIT, 32'h1);
    wreg(`ADDR_COUNT_RESTART, 32'h0);
    wreg(`ADDR_COUNT_UNIT_SEL, 32'h0);
    wreg(`ADDR_INC_SOURCE_SEL, 32'h1);
    wreg(`ADDR_COUNT_LIMIT, 32'hFFFF);
    wreg(`ADDR_COUNT_RESTART, 32'h0);
    tog(1);
    rr_chk(`ADDR_COUNT_NOW, 32'h1, "count of unit two done");
    `CHK("unit two flag", 1'b1, limit_two_flag)
    $display("test unit chaining done");
    fseq = {seed, lfsr(seed)};
    wreg(`ADDR_FRAME_SEQ, fseq);
    wreg(`ADDR_META_ENABLE, 32'h1);
    @(posedge clock);
    src[3] <= 1'b1;
    @(posedge clock);
    src[3] <= 1'b0;
    @(negedge clock);
    `CHK("metadata valid", 1'b1, meta_frame_valid)
    `CHK("metadata sequence", fseq, meta_frame_seq)
    rr_chk(`ADDR_FRAME_SEQ, fseq + 1, "frame sequence advanced");
    $display("test frame sequence done");
    wreg(`ADDR_PULSE_SRC_SEL, 32'h2);
    wreg(`ADDR_PULSE_EDGE_SEL, 32'h2);
    wreg(`ADDR_PULSE_DELAY_US, 32'h1);
    @(posedge clock);
    src[1] <= ~src[1];
    wait_pulse(1'b1, n);
    `CHK("delay cycles", 1 + `US_CYCLES, n)
    @(posedge clock);
    src[1] <= ~src[1];
    wait_pulse(1'b0, n);
    `CHK("width cycles", 499, n)
    repeat (200) @(posedge clock);
    `CHK("edge in pulse ignored", 1'b0, timer_pulse)
    wreg(`ADDR_PULSE_SRC_SEL, 32'h4);
    wreg(`ADDR_PULSE_EDGE_SEL, 32'h0);
    wreg(`ADDR_PULSE_DELAY_US, 32'h0);
    @(posedge clock);
    src[4] <= 1'b1;
    wait_pulse(1'b1, n);
    `CHK("pin start cycles", 3, n)
    wait_pulse(1'b0, n);
    `CHK("pin pulse width", 10 * `US_CYCLES, n)
    $display("test pulse timer done");
    end_of_test;
  end
endmodule
`default_nettype wire
